/* File: src/mqcf_cfg_regs.sv */
// configuration register file: ten registers written and read in sequence
`timescale 1ns/1ps
`default_nettype none
module mqcf_cfg_regs
  import mqcf_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       wr_pulse_i,
  input  wire logic       rd_pulse_i,
  input  wire logic [7:0] wr_byte_i,
  output logic      [4:0] port_cfg_o,
  output logic      [4:0] ql1_o,
  output logic      [3:0] ql2_o,
  output logic      [5:0] words_per_cell_o,
  output logic      [7:0] set_hi_o [3],
  output logic      [7:0] clr_hi_o [3],
  output logic      [7:0] rd_byte_o
);
  logic [3:0] wr_idx;
  logic       wr_done;
  logic [3:0] rd_idx;
  logic [7:0] next_rd_byte;

  // ----------------------------------------------------------------
  // write sequence; locked after the tenth write until reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_idx      <= IDX_PORT;
      wr_done     <= 1'b0;
      port_cfg_o  <= RST_PORT;
      ql1_o       <= RST_QL1;
      ql2_o       <= RST_QL2;
      words_per_cell_o      <= RST_WORDS_PER_CELL;
      set_hi_o[0] <= RST_Q1_SET_HI;
      set_hi_o[1] <= RST_Q2_SET_HI;
      set_hi_o[2] <= RST_Q3_SET_HI;
      clr_hi_o[0] <= RST_Q1_SET_HI;
      clr_hi_o[1] <= RST_Q2_SET_HI;
      clr_hi_o[2] <= RST_Q3_SET_HI;
    end
    else if (wr_pulse_i && !wr_done)
    begin
      unique case (wr_idx)
        IDX_PORT:   port_cfg_o  <= wr_byte_i[4:0];
        IDX_QL1:    ql1_o       <= wr_byte_i[4:0];
        IDX_QL2:    ql2_o       <= wr_byte_i[3:0];
        IDX_WORDS_PER_CELL:   words_per_cell_o      <= wr_byte_i[5:0];
        IDX_Q1_SET: set_hi_o[0] <= wr_byte_i;
        IDX_Q1_CLR: clr_hi_o[0] <= wr_byte_i;
        IDX_Q2_SET: set_hi_o[1] <= wr_byte_i;
        IDX_Q2_CLR: clr_hi_o[1] <= wr_byte_i;
        IDX_Q3_SET: set_hi_o[2] <= wr_byte_i;
        IDX_Q3_CLR: clr_hi_o[2] <= wr_byte_i;
        default:    ;
      endcase
      if (wr_idx == IDX_LAST)
        wr_done <= 1'b1;
      else
        wr_idx <= wr_idx + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // read sequence: the pointer moves first, then the next byte shows
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (rd_idx)
      IDX_PORT:   next_rd_byte = {3'h0, port_cfg_o};
      IDX_QL1:    next_rd_byte = {3'h0, ql1_o};
      IDX_QL2:    next_rd_byte = {4'h0, ql2_o};
      IDX_WORDS_PER_CELL:   next_rd_byte = {2'h0, words_per_cell_o};
      IDX_Q1_SET: next_rd_byte = set_hi_o[0];
      IDX_Q1_CLR: next_rd_byte = clr_hi_o[0];
      IDX_Q2_SET: next_rd_byte = set_hi_o[1];
      IDX_Q2_CLR: next_rd_byte = clr_hi_o[1];
      IDX_Q3_SET: next_rd_byte = set_hi_o[2];
      IDX_Q3_CLR: next_rd_byte = clr_hi_o[2];
      default:    next_rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rd_idx <= IDX_PORT;
    else if (rd_pulse_i)
      rd_idx <= (rd_idx == IDX_LAST) ? IDX_PORT : rd_idx + 4'h1;
  end

  // registered read data
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rd_byte_o <= 8'h00;
    else
      rd_byte_o <= next_rd_byte;
  end
endmodule : mqcf_cfg_regs
`default_nettype wire

/* File: src/mqcf_pkg.sv */
// package: constants and types for the queue cell-flag and configuration block
package mqcf_pkg;
  // ----------------------------------------------------------------
  // configuration sequence
  // ----------------------------------------------------------------
  localparam int unsigned CFG_COUNT    = 10;
  localparam logic [3:0]  IDX_PORT     = 4'h0;
  localparam logic [3:0]  IDX_QL1      = 4'h1;
  localparam logic [3:0]  IDX_QL2      = 4'h2;
  localparam logic [3:0]  IDX_WORDS_PER_CELL     = 4'h3;
  localparam logic [3:0]  IDX_Q1_SET   = 4'h4;
  localparam logic [3:0]  IDX_Q1_CLR   = 4'h5;
  localparam logic [3:0]  IDX_Q2_SET   = 4'h6;
  localparam logic [3:0]  IDX_Q2_CLR   = 4'h7;
  localparam logic [3:0]  IDX_Q3_SET   = 4'h8;
  localparam logic [3:0]  IDX_Q3_CLR   = 4'h9;
  localparam logic [3:0]  IDX_LAST     = 4'h9;
  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [4:0]  TOTAL_BLOCKS     = 5'h10;
  localparam logic [8:0]  WORDS_PER_BLOCK  = 9'h100;
  localparam logic [4:0]  RST_PORT         = 5'h00;
  localparam logic [4:0]  RST_QL1          = 5'h08;
  localparam logic [3:0]  RST_QL2          = 4'h6;
  localparam logic [5:0]  RST_WORDS_PER_CELL         = 6'h1B;
  // set threshold: six, five and three cells short of capacity for queues one to three; clear: set minus one
  localparam logic [7:0]  RST_Q1_SET_HI    = 8'h22;
  localparam logic [7:0]  RST_Q2_SET_HI    = 8'h19;
  localparam logic [7:0]  RST_Q3_SET_HI    = 8'h07;
  localparam int unsigned HANDOFF_EDGES    = 2;
  localparam int unsigned FLAG_RISE_EDGES  = 2;
  typedef logic [8:0] mqcf_count_t;
endpackage : mqcf_pkg

/* File: src/mqcf_top.sv */
// top: per-queue cell full and threshold flags plus programming port
`timescale 1ns/1ps
`default_nettype none
module mqcf_top
  import mqcf_pkg::*;
#(
  parameter int unsigned NUM_QUEUES = 3
)(
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  bus_request_n_i,
  input  wire logic                  data_strobe_n_i,
  input  wire logic                  read_not_write_i,
  input  wire logic                  prog_output_enable_n_i,
  input  wire logic [7:0]            prog_bus_i,
  input  wire logic [NUM_QUEUES-1:0] cell_written_i,
  input  wire logic [NUM_QUEUES-1:0] cell_read_i,
  output logic      [7:0]            prog_bus_o,
  output logic                       prog_bus_oe_n_o,
  output logic                       data_write_ready_o,
  output logic                       queue1_full_n_o,
  output logic                       queue2_full_n_o,
  output logic                       queue3_full_n_o,
  output logic                       queue1_threshold_flag_o,
  output logic                       queue2_threshold_flag_o,
  output logic                       queue3_threshold_flag_o,
  output logic      [4:0]            bus_format_cfg_o
);
  import mqcf_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic        strobe_q;
  logic        wr_pulse;
  logic        rd_pulse;
  logic        req_pipe;
  logic [4:0]  ql1;
  logic [3:0]  ql2;
  logic [5:0]  words_per_cell;
  logic [4:0]  port_cfg;
  logic [7:0]  set_hi [3];
  logic [7:0]  clr_hi [3];
  logic [7:0]  rd_byte;
  logic [4:0]  depth [3];
  mqcf_count_t max_cells [3];
  mqcf_count_t cells [3];
  mqcf_count_t set_thr [3];
  mqcf_count_t clr_thr [3];
  logic [2:0]  full_n;
  logic [2:0]  thr_flag;
  logic [2:0]  rel_full;
  logic [2:0]  rel_full_q;
  logic [2:0]  rel_thr;
  logic [2:0]  rel_thr_q;

  // whole cells that fit a number of 256-word blocks
  // the divide only sees configuration registers, so it settles between
  // programming and the first cell write; a zero cell size would divide
  // by zero, so it yields no cells at all
  function automatic mqcf_count_t cells_fit(input logic [4:0] blocks,
                                            input logic [5:0] words);
    logic [12:0] total;
    total = 13'({blocks, 8'h00});
    if (words == 6'h00)
      cells_fit = 9'h000;
    else
      cells_fit = 9'(total / 13'(words));
  endfunction : cells_fit

  // ----------------------------------------------------------------
  // strobe edge detection; the strobe is taken as synchronous
  // ----------------------------------------------------------------
  // the strobe is a slow host signal; comparing it with its previous
  // sample gives one-cycle edge pulses. the reset value is the idle
  // level, so no false edge follows reset
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      strobe_q <= 1'b1;
    else
      strobe_q <= data_strobe_n_i;
  end

  // write needs ready low; ready is the registered output
  // using the registered copy keeps the ownership decision aligned
  // with the level the host sees on the pin
  assign wr_pulse = strobe_q && !data_strobe_n_i && !read_not_write_i
                    && !data_write_ready_o;
  assign rd_pulse = !strobe_q && data_strobe_n_i && read_not_write_i;

  mqcf_cfg_regs u_cfg (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .wr_pulse_i (wr_pulse),
    .rd_pulse_i (rd_pulse),
    .wr_byte_i  (prog_bus_i),
    .port_cfg_o (port_cfg),
    .ql1_o      (ql1),
    .ql2_o      (ql2),
    .words_per_cell_o     (words_per_cell),
    .set_hi_o   (set_hi),
    .clr_hi_o   (clr_hi),
    .rd_byte_o  (rd_byte)
  );

  // ----------------------------------------------------------------
  // bus grant handshake: two clock edges from request to ready change
  // ----------------------------------------------------------------
  // one flop samples the request and the output flop follows it, so the
  // ready pin changes on the second edge that sees the new request level;
  // the same path hands ownership back when the request is released
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      req_pipe           <= 1'b1;
      data_write_ready_o <= 1'b1;
    end
    else
    begin
      req_pipe           <= bus_request_n_i;
      data_write_ready_o <= req_pipe;
    end
  end

  // ----------------------------------------------------------------
  // programming bus drive, registered so the pins never glitch
  // ----------------------------------------------------------------
  // enable and data change one edge after the controls, a latency
  // traded for glitch-free drive of the shared bus
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      prog_bus_oe_n_o <= 1'b1;
      prog_bus_o      <= 8'h00;
    end
    else
    begin
      prog_bus_oe_n_o <= prog_output_enable_n_i || !read_not_write_i;
      prog_bus_o      <= rd_byte;
    end
  end

  // ----------------------------------------------------------------
  // capacity and threshold derivation
  // ----------------------------------------------------------------
  // queue three takes whatever blocks the first two leave; the sum is
  // sized to five bits, which holds the largest legal pair, and the
  // second term of the clamp catches an oversized depth one
  always_comb
  begin
    depth[0] = ql1;
    depth[1] = {1'b0, ql2};
    // remaining memory; clamp so an overcommit leaves queue three empty
    if (5'(ql1 + {1'b0, ql2}) >= TOTAL_BLOCKS || ql1 >= TOTAL_BLOCKS)
      depth[2] = 5'h00;
    else
      depth[2] = 5'(TOTAL_BLOCKS - ql1 - {1'b0, ql2});
    for (int q = 0; q < 3; q++)
    begin
      max_cells[q] = cells_fit(depth[q], words_per_cell);
      set_thr[q]   = {set_hi[q], 1'b1};
      clr_thr[q]   = {clr_hi[q], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // stored cell counters; a write and a read in one cycle cancel
  // ----------------------------------------------------------------
  // the count stops at zero: a read pulse on an empty queue is a fault
  // of the outside data path and must not wrap the count around
  always_ff @(posedge clk_i)
  begin
    for (int q = 0; q < 3; q++)
    begin
      if (sys_rst_i)
        cells[q] <= 9'h000;
      else if (cell_written_i[q] && !cell_read_i[q])
        cells[q] <= cells[q] + 9'h001;
      else if (cell_read_i[q] && !cell_written_i[q] && cells[q] != 9'h000)
        cells[q] <= cells[q] - 9'h001;
    end
  end

  // release events: a read that frees room or reaches the clear value
  // both only count while the flag is low, so a read with the flag
  // already high leaves nothing pending in the delay stage
  always_comb
  begin
    for (int q = 0; q < 3; q++)
    begin
      rel_full[q] = cell_read_i[q] && !cell_written_i[q] && !full_n[q];
      rel_thr[q]  = cell_read_i[q] && !cell_written_i[q] && !thr_flag[q]
                    && (cells[q] - 9'h001 == clr_thr[q]);
    end
  end

  // delay stage so the flags rise on the second edge after the read
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rel_full_q <= 3'b000;
      rel_thr_q  <= 3'b000;
    end
    else
    begin
      rel_full_q <= rel_full;
      rel_thr_q  <= rel_thr;
    end
  end

  // ----------------------------------------------------------------
  // full flags: low at capacity, high again two edges after a read
  // ----------------------------------------------------------------
  // a write that reaches capacity outranks a pending release in the
  // same cycle, so the flag never shows room that is not there; a zero
  // capacity pulls the flag low on every edge with no release pending
  always_ff @(posedge clk_i)
  begin
    for (int q = 0; q < 3; q++)
    begin
      if (sys_rst_i)
        full_n[q] <= 1'b1;
      else if (cell_written_i[q] && !cell_read_i[q]
               && cells[q] + 9'h001 >= max_cells[q])
        full_n[q] <= 1'b0;
      else if (rel_full_q[q])
        full_n[q] <= 1'b1;
      else if (max_cells[q] == 9'h000)
        full_n[q] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // threshold flags with hysteresis
  // ----------------------------------------------------------------
  // falling outranks rising, as for the full flag; between the two
  // limits the flag keeps its last state, which gives the hysteresis
  always_ff @(posedge clk_i)
  begin
    for (int q = 0; q < 3; q++)
    begin
      if (sys_rst_i)
        thr_flag[q] <= 1'b1;
      else if (cell_written_i[q] && !cell_read_i[q]
               && cells[q] + 9'h001 == set_thr[q])
        thr_flag[q] <= 1'b0;
      else if (rel_thr_q[q])
        thr_flag[q] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // the flag registers drive the pins directly, nothing in between
  assign queue1_full_n_o         = full_n[0];
  assign queue2_full_n_o         = full_n[1];
  assign queue3_full_n_o         = full_n[2];
  assign queue1_threshold_flag_o = thr_flag[0];
  assign queue2_threshold_flag_o = thr_flag[1];
  assign queue3_threshold_flag_o = thr_flag[2];

  // format register exported for the data path outside this block
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      bus_format_cfg_o <= RST_PORT;
    else
      bus_format_cfg_o <= port_cfg;
  end
endmodule : mqcf_top
`default_nettype wire

/* File: testbench/mqcf_host.sv */
// host model: programming-port side of the queue flag block
`timescale 1ns/1ps
`default_nettype none
module mqcf_host (
  input  wire logic       clk_i,
  output logic            bus_request_n_o,
  output logic            data_strobe_n_o,
  output logic            read_not_write_o,
  output logic            prog_output_enable_n_o,
  output logic      [7:0] prog_bus_drv_o
);
  // ------------------
  // bus cycles
  // ------------------
  // idle: no request, strobe high, reading with outputs enabled
  initial
  begin
    bus_request_n_o        = 1'b1;
    data_strobe_n_o        = 1'b1;
    read_not_write_o       = 1'b1;
    prog_output_enable_n_o = 1'b0;
    prog_bus_drv_o         = 8'h00;
  end
  // asked only after reset: once before the cell traffic and once after it
  task automatic ask_bus(input logic req_n);
    @(posedge clk_i);
    bus_request_n_o <= req_n;
  endtask : ask_bus
  // output enable request, changed just after an edge
  task automatic set_oe(input logic oe_n);
    @(posedge clk_i);
    prog_output_enable_n_o <= oe_n;
  endtask : set_oe
  // byte held across the falling strobe, then left as its inverse
  task automatic put_byte(input logic [7:0] b);
    @(posedge clk_i);
    read_not_write_o <= 1'b0;
    prog_bus_drv_o   <= b;
    @(posedge clk_i);
    data_strobe_n_o <= 1'b0;
    @(posedge clk_i);
    data_strobe_n_o <= 1'b1;
    @(posedge clk_i);
    prog_bus_drv_o <= ~b;
  endtask : put_byte
  // rising strobe in read mode; waits out the three-edge update
  task automatic next_reg();
    @(posedge clk_i);
    read_not_write_o <= 1'b1;
    data_strobe_n_o  <= 1'b0;
    @(posedge clk_i);
    data_strobe_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : next_reg
endmodule : mqcf_host
`default_nettype wire

/* File: testbench/mqcf_top_properties.sv */
// checker: port-level properties of the queue flag and config block
`timescale 1ns/1ps
`default_nettype none
module mqcf_top_chk
#(
  parameter int unsigned NUM_QUEUES = 3
)(
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  bus_request_n_i,
  input wire logic                  read_not_write_i,
  input wire logic                  prog_output_enable_n_i,
  input wire logic [NUM_QUEUES-1:0] cell_written_i,
  input wire logic [NUM_QUEUES-1:0] cell_read_i,
  input wire logic                  prog_bus_oe_n_o,
  input wire logic                  data_write_ready_o,
  input wire logic                  queue1_full_n_o,
  input wire logic                  queue1_threshold_flag_o,
  input wire logic [4:0]            bus_format_cfg_o
);
  // ------------------
  // properties
  // ------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // a cell leaves a full queue with no refill in the same cycle
  sequence read_while_full;
    cell_read_i[0] && !cell_written_i[0] && !queue1_full_n_o;
  endsequence
  ready_follows_a: assert property (
    !$past(sys_rst_i) && !$past(sys_rst_i, 2) |-> data_write_ready_o == $past(bus_request_n_i, 2))
    else $error("write ready does not follow bus request");
  bus_drive_a: assert property (
    !$past(sys_rst_i) && $past(!prog_output_enable_n_i && read_not_write_i) |-> !prog_bus_oe_n_o)
    else $error("programming bus not driven in read mode");
  bus_release_a: assert property (
    $past(prog_output_enable_n_i || !read_not_write_i) |-> prog_bus_oe_n_o)
    else $error("programming bus driven while released");
  full_fall_a: assert property (
    $fell(queue1_full_n_o) |-> $past(cell_written_i[0]))
    else $error("full flag fell without a cell write");
  full_hold_a: assert property (
    read_while_full |=> !queue1_full_n_o ##1 queue1_full_n_o)
    else $error("full flag not high on the second edge after a read");
  full_rise_a: assert property (
    $rose(queue1_full_n_o) && !$past(sys_rst_i) |-> $past(cell_read_i[0], 2))
    else $error("full flag rose without a cell read");
  thr_fall_a: assert property (
    $fell(queue1_threshold_flag_o) |-> $past(cell_written_i[0]))
    else $error("threshold flag fell without a cell write");
  thr_rise_a: assert property (
    $rose(queue1_threshold_flag_o) && !$past(sys_rst_i) |-> $past(cell_read_i[0], 2))
    else $error("threshold flag rose off the read timing");
  fmt_hold_a: assert property (
    !$past(sys_rst_i) && $past(data_write_ready_o, 2) |-> $stable(bus_format_cfg_o))
    else $error("format changed while data port owned input");
endmodule : mqcf_top_chk
bind mqcf_top mqcf_top_chk #(.NUM_QUEUES(NUM_QUEUES)) u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_request_n_i(bus_request_n_i),
  .read_not_write_i(read_not_write_i), .prog_output_enable_n_i(prog_output_enable_n_i),
  .cell_written_i(cell_written_i), .cell_read_i(cell_read_i),
  .prog_bus_oe_n_o(prog_bus_oe_n_o), .data_write_ready_o(data_write_ready_o),
  .queue1_full_n_o(queue1_full_n_o), .queue1_threshold_flag_o(queue1_threshold_flag_o),
  .bus_format_cfg_o(bus_format_cfg_o));
`default_nettype wire

/* File: testbench/tb_top.sv */
// testbench: programming port and cell flag scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mqcf_pkg::*;
  // ------------------
  // hookup
  // ------------------
  logic       clk_i;
  logic       sys_rst_i;
  logic [2:0] wr_q;
  logic [2:0] rd_q;
  int         errors;
  int         checked;
  wire        req_n, ds_n, rnw, poe_n, oe_n, ready;
  wire  [7:0] bus_in, bus_out;
  wire  [4:0] fmt;
  wire  [2:0] full_n, thr_n;
  mqcf_top #(.NUM_QUEUES(3)) u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_request_n_i(req_n),
    .data_strobe_n_i(ds_n), .read_not_write_i(rnw), .prog_output_enable_n_i(poe_n),
    .prog_bus_i(bus_in), .cell_written_i(wr_q), .cell_read_i(rd_q),
    .prog_bus_o(bus_out), .prog_bus_oe_n_o(oe_n), .data_write_ready_o(ready),
    .queue1_full_n_o(full_n[0]), .queue2_full_n_o(full_n[1]), .queue3_full_n_o(full_n[2]),
    .queue1_threshold_flag_o(thr_n[0]), .queue2_threshold_flag_o(thr_n[1]),
    .queue3_threshold_flag_o(thr_n[2]), .bus_format_cfg_o(fmt));
  mqcf_host u_host (
    .clk_i(clk_i), .bus_request_n_o(req_n), .data_strobe_n_o(ds_n),
    .read_not_write_o(rnw), .prog_output_enable_n_o(poe_n), .prog_bus_drv_o(bus_in));
  // 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ------------------
  // helpers
  // ------------------
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // one-cycle cell pulse; returns just after the edge that takes it
  task automatic pulse(input int q, input logic rd);
    @(posedge clk_i);
    if (rd) rd_q[q] <= 1'b1;
    else wr_q[q] <= 1'b1;
    @(posedge clk_i);
    rd_q <= 3'h0;
    wr_q <= 3'h0;
    #1;
  endtask : pulse
  task automatic test_done();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // ------------------
  // scenarios
  // ------------------
  task automatic test_defaults();
    logic [7:0] ex [10] = '{8'h00, 8'h08, 8'h06, 8'h1B, 8'h22, 8'h22, 8'h19, 8'h19,
                            8'h07, 8'h07};
    @(posedge clk_i) #1;
    cmp(ready, 1'b1);
    cmp(oe_n, 1'b0);
    cmp({full_n, thr_n}, 6'h3F);
    u_host.set_oe(1'b1);
    @(posedge clk_i) #1 cmp(oe_n, 1'b1);
    u_host.set_oe(1'b0);
    @(posedge clk_i) #1 cmp(oe_n, 1'b0);
    for (int i = 0; i < 10; i++)
    begin
      cmp(bus_out, ex[i]);
      u_host.next_reg();
      #1;
    end
    cmp(bus_out, ex[0]);
  endtask : test_defaults
  // refused write, grant, ten writes, ignored extra, read back
  task automatic test_program();
    logic [7:0] wr [10] = '{8'hEF, 8'hE1, 8'hF1, 8'h20, 8'h02, 8'h01, 8'h01, 8'h00,
                            8'h03, 8'h02};
    logic [7:0] rb [10] = '{8'h0F, 8'h01, 8'h01, 8'h20, 8'h02, 8'h01, 8'h01, 8'h00,
                            8'h03, 8'h02};
    u_host.put_byte(8'h1E);
    #1;
    cmp(fmt, 5'h00);
    cmp(oe_n, 1'b1);
    u_host.ask_bus(1'b0);
    @(posedge clk_i) #1 cmp(ready, 1'b1);
    @(posedge clk_i) #1 cmp(ready, 1'b0);
    foreach (wr[i]) u_host.put_byte(wr[i]);
    u_host.put_byte(8'h15);
    u_host.ask_bus(1'b1);
    @(posedge clk_i) #1 cmp(ready, 1'b0);
    @(posedge clk_i) #1 cmp(ready, 1'b1);
    cmp(fmt, 5'h0F);
    for (int i = 0; i < 10; i++)
    begin
      cmp(bus_out, rb[i]);
      u_host.next_reg();
      #1;
    end
  endtask : test_program
  // fill to capacity, then drain to empty, watching both flags
  task automatic test_flags(input int q, input int cap, input int set, input int clr);
    logic et;
    et = 1'b1;
    for (int n = 1; n <= cap; n++)
    begin
      pulse(q, 1'b0);
      et = et && (n != set);
      cmp({full_n[q], thr_n[q]}, {1'(n < cap), et});
    end
    for (int n = cap - 1; n >= 0; n--)
    begin
      pulse(q, 1'b1);
      cmp({full_n[q], thr_n[q]}, {1'(n + 1 < cap), et});
      @(posedge clk_i) #1;
      et = et || (n == clr);
      cmp({full_n[q], thr_n[q]}, {1'b1, et});
    end
  endtask : test_flags
  // reset in mid-run rewinds the pointers and reopens writes
  task automatic test_reset();
    u_host.next_reg();
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    cmp(bus_out, 8'h00);
    u_host.ask_bus(1'b0);
    u_host.put_byte(8'h03);
    #1;
    cmp(fmt, 5'h03);
    u_host.ask_bus(1'b1);
  endtask : test_reset
  // main sequence
  initial
  begin
    errors    = 0;
    checked   = 0;
    sys_rst_i = 1'b1;
    wr_q      = 3'h0;
    rd_q      = 3'h0;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    test_defaults();
    test_program();
    test_flags(0, 8, 5, 2);
    test_flags(1, 8, 3, 0);
    test_flags(2, 112, 7, 4);
    test_reset();
    test_done();
  end
  // watchdog, about six times the expected run
  initial
  begin
    repeat (5000) @(posedge clk_i);
    errors++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
